/* scb_pkg.sv */
// Package: register map, field positions and timing constants of the bank
package scb_pkg;
    localparam int SCB_CLK_HZ = 100000000;
    localparam logic [7:0] SCB_ADDR_CH4_FILT = 8'h55;
    localparam logic [7:0] SCB_ADDR_ESM_DLY = 8'h9e;
    localparam logic [7:0] SCB_ADDR_GCTRL = 8'h9f;
    localparam logic [7:0] SCB_ADDR_AUTO_MASK_POWER_ON = 8'ha1;
    localparam logic [7:0] SCB_ADDR_AUTO_MASK_POWER_OFF = 8'ha2;
    localparam logic [7:0] SCB_ADDR_TOUT_HI = 8'ha5;
    localparam logic [7:0] SCB_ADDR_TOUT_LO = 8'ha6;
    localparam logic [7:0] SCB_ADDR_REL_UP = 8'ha8;
    localparam logic [7:0] SCB_ADDR_REL_DN = 8'ha9;
    localparam logic [7:0] SCB_ADDR_INT_STAT = 8'hb0;
    localparam logic [7:0] SCB_REG_RESET = 8'h00;
    localparam int SCB_BIT_OV_ROUTE = 4;
    localparam int SCB_BIT_UV_ROUTE = 3;
    localparam int SCB_BIT_BIST = 7;
    localparam int SCB_BIT_WDT = 6;
    localparam int SCB_BIT_MR = 5;
    localparam int SCB_DEB_LSB = 3;
    localparam int SCB_MON_LSB = 1;
    localparam int SCB_NMON = 3;
    localparam int SCB_DEB_US_0 = 10;
    localparam int SCB_DEB_US_1 = 25;
    localparam int SCB_DEB_US_2 = 50;
    localparam int SCB_DEB_US_3 = 100;
    localparam int SCB_CYC_PER_US = SCB_CLK_HZ / 1000000;
    localparam int SCB_CYC_PER_MS = SCB_CLK_HZ / 1000;
    localparam int SCB_RST_US_0 = 200;
    localparam int SCB_RST_MS_1 = 1;
    localparam int SCB_RST_MS_2 = 10;
    localparam int SCB_RST_MS_3 = 16;
    localparam int SCB_RST_MS_4 = 20;
    localparam int SCB_RST_MS_5 = 70;
    localparam int SCB_RST_MS_6 = 100;
    localparam int SCB_RST_MS_7 = 200;
    localparam int SCB_ESM_MS_MAX = 864;
    localparam logic [2:0] SCB_FC_250HZ = 3'h2;
    localparam logic [2:0] SCB_FC_2KHZ = 3'h5;
endpackage

/* scb_debounce.sv */
// Input synchroniser followed by a programmable stability debounce
`timescale 1ns/1ps
module scb_debounce
    import scb_pkg::*;
#(
    parameter int CW = 24
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    input wire logic [CW-1:0] stable_cyc,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic [CW-1:0] cnt_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else if (ce) begin
            s1_r <= din;
            s2_r <= s1_r;
        end
    end

    // Output follows only after the input held steady for stable_cyc
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
            dout <= 1'b0;
        end else if (ce) begin
            if (s2_r == dout) begin
                cnt_r <= '0;
            end else if (cnt_r >= stable_cyc) begin
                dout <= s2_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

/* scb_delay.sv */
// Counter that reports once its armed condition has lasted the load count
`timescale 1ns/1ps
module scb_delay #(
    parameter int CW = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic arm,
    input wire logic [CW-1:0] limit,
    output logic done
);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (ce) begin
            if (!arm) begin
                cnt_r <= '0;
                done <= 1'b0;
            end else if (cnt_r >= limit) begin
                done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

/* scb_bank.sv */
// Supervisor configuration bank with reset routing, error monitor, masking
// Notes on behaviour
// - Bit4 routes ch4 fast overvoltage to reset
// - Bit3 routes ch4 fast undervoltage to reset
// - Cutoff codes 010..101 valid, others invalid
// - Error monitor delay 1 to 864 ms
// - Control bit7 write one starts self test
// - Control bit6 soft watchdog enable with pin
// - Control bit5 holds reset output low
// - Control bits4:3 choose error debounce time
// - Control bits2:0 choose reset release delay
// - Power-up automask enables for monitors 2-4
// - Power-down automask enables for monitors 2-4
// - Sixteen-bit millisecond sequence timeout from bytes
// - Power-up mask release threshold per monitor
// - Power-down mask release threshold per monitor
// - Fault flags clear only by write-one
`timescale 1ns/1ps
module scb_bank
    import scb_pkg::*;
#(
    parameter int RST_W = 32,
    parameter int MS_CYC = SCB_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic ch4_fast_ov,
    input wire logic ch4_fast_uv,
    input wire logic error_signal_monitor,
    input wire logic watchdog_enable_pin,
    input wire logic [SCB_NMON-1:0] rail_above_off,
    input wire logic [SCB_NMON-1:0] rail_above_uv,
    input wire logic [SCB_NMON-1:0] rail_fault_uv,
    input wire logic power_up_seq,
    input wire logic power_down_seq,
    output logic reset_n_out,
    output logic reset_n_oe_n,
    output logic watchdog_enable,
    output logic self_test_start,
    output logic [2:0] slow_filter_cutoff,
    output logic cutoff_invalid,
    output logic error_fault,
    output logic [SCB_NMON-1:0] auto_mask_active,
    output logic seq_timeout_fault
);
    logic [7:0] filt_r, esm_r, ctrl_r, amon_r, amoff_r;
    logic [7:0] thi_r, tlo_r, rup_r, rdn_r, stat_r;
    logic wdp_s1_r, wdp_s2_r;
    logic ov_s1_r, ov_s2_r, uv_s1_r, uv_s2_r;
    logic [SCB_NMON-1:0] mask_r;
    logic [23:0] deb_cyc;
    logic [31:0] esm_cyc, tout_cyc;
    logic [RST_W-1:0] rel_cyc;
    logic error_monitor_debounce, esm_done, tout_done, rel_done, fault_now;
    logic [15:0] timeout_ms_value;

    wire wr_hit = ce && reg_wr;

    // Plain read/write storage; reserved bits kept as written
    always_ff @(posedge core_clk) begin
        if (rst) begin
            filt_r <= SCB_REG_RESET;
            esm_r <= SCB_REG_RESET;
            ctrl_r <= SCB_REG_RESET;
            amon_r <= SCB_REG_RESET;
            amoff_r <= SCB_REG_RESET;
            thi_r <= SCB_REG_RESET;
            tlo_r <= SCB_REG_RESET;
            rup_r <= SCB_REG_RESET;
            rdn_r <= SCB_REG_RESET;
        end else if (wr_hit) begin
            case (reg_addr)
                SCB_ADDR_CH4_FILT: filt_r <= reg_wdata;
                SCB_ADDR_ESM_DLY: esm_r <= reg_wdata;
                SCB_ADDR_GCTRL: ctrl_r <= reg_wdata;
                SCB_ADDR_AUTO_MASK_POWER_ON: amon_r <= reg_wdata;
                SCB_ADDR_AUTO_MASK_POWER_OFF: amoff_r <= reg_wdata;
                SCB_ADDR_TOUT_HI: thi_r <= reg_wdata;
                SCB_ADDR_TOUT_LO: tlo_r <= reg_wdata;
                SCB_ADDR_REL_UP: rup_r <= reg_wdata;
                SCB_ADDR_REL_DN: rdn_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    SCB_ADDR_CH4_FILT: reg_rdata <= filt_r;
                    SCB_ADDR_ESM_DLY: reg_rdata <= esm_r;
                    SCB_ADDR_GCTRL: reg_rdata <= ctrl_r;
                    SCB_ADDR_AUTO_MASK_POWER_ON: reg_rdata <= amon_r;
                    SCB_ADDR_AUTO_MASK_POWER_OFF: reg_rdata <= amoff_r;
                    SCB_ADDR_TOUT_HI: reg_rdata <= thi_r;
                    SCB_ADDR_TOUT_LO: reg_rdata <= tlo_r;
                    SCB_ADDR_REL_UP: reg_rdata <= rup_r;
                    SCB_ADDR_REL_DN: reg_rdata <= rdn_r;
                    SCB_ADDR_INT_STAT: reg_rdata <= stat_r;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Self test is a one-cycle request issued on every write of one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            self_test_start <= 1'b0;
        end else if (ce) begin
            self_test_start <= reg_wr && reg_addr == SCB_ADDR_GCTRL
                && reg_wdata[SCB_BIT_BIST];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wdp_s1_r <= 1'b0;
            wdp_s2_r <= 1'b0;
            ov_s1_r <= 1'b0;
            ov_s2_r <= 1'b0;
            uv_s1_r <= 1'b0;
            uv_s2_r <= 1'b0;
        end else if (ce) begin
            wdp_s1_r <= watchdog_enable_pin;
            wdp_s2_r <= wdp_s1_r;
            ov_s1_r <= ch4_fast_ov;
            ov_s2_r <= ov_s1_r;
            uv_s1_r <= ch4_fast_uv;
            uv_s2_r <= uv_s1_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdog_enable <= 1'b0;
        end else if (ce) begin
            watchdog_enable <= wdp_s2_r && ctrl_r[SCB_BIT_WDT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            slow_filter_cutoff <= SCB_FC_250HZ;
            cutoff_invalid <= 1'b0;
        end else if (ce) begin
            slow_filter_cutoff <= filt_r[2:0];
            cutoff_invalid <= filt_r[2:0] < SCB_FC_250HZ
                || filt_r[2:0] > SCB_FC_2KHZ;
        end
    end

    always_comb begin
        case (ctrl_r[4:3])
            2'h0: deb_cyc = 24'(SCB_DEB_US_0 * SCB_CYC_PER_US);
            2'h1: deb_cyc = 24'(SCB_DEB_US_1 * SCB_CYC_PER_US);
            2'h2: deb_cyc = 24'(SCB_DEB_US_2 * SCB_CYC_PER_US);
            default: deb_cyc = 24'(SCB_DEB_US_3 * SCB_CYC_PER_US);
        endcase
    end

    scb_debounce #(.CW(24)) u_error_monitor_debounce (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .din(error_signal_monitor),
        .stable_cyc(deb_cyc),
        .dout(error_monitor_debounce)
    );

    // Code 0 gives 1 ms; linear scale reaching 864 ms at full code
    always_comb begin
        esm_cyc = 32'(MS_CYC) + 32'((esm_r * (SCB_ESM_MS_MAX - 1) / 255)
            * MS_CYC);
    end

    scb_delay #(.CW(32)) u_esm_dly (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .arm(error_monitor_debounce),
        .limit(esm_cyc),
        .done(esm_done)
    );

    assign error_fault = esm_done;

    always_comb begin
        case (ctrl_r[2:0])
            3'h0: rel_cyc = RST_W'(SCB_RST_US_0 * SCB_CYC_PER_US);
            3'h1: rel_cyc = RST_W'(SCB_RST_MS_1 * MS_CYC);
            3'h2: rel_cyc = RST_W'(SCB_RST_MS_2 * MS_CYC);
            3'h3: rel_cyc = RST_W'(SCB_RST_MS_3 * MS_CYC);
            3'h4: rel_cyc = RST_W'(SCB_RST_MS_4 * MS_CYC);
            3'h5: rel_cyc = RST_W'(SCB_RST_MS_5 * MS_CYC);
            3'h6: rel_cyc = RST_W'(SCB_RST_MS_6 * MS_CYC);
            default: rel_cyc = RST_W'(SCB_RST_MS_7 * MS_CYC);
        endcase
    end

    assign fault_now = (ov_s2_r && filt_r[SCB_BIT_OV_ROUTE])
        || (uv_s2_r && filt_r[SCB_BIT_UV_ROUTE])
        || ctrl_r[SCB_BIT_MR] || esm_done;

    scb_delay #(.CW(RST_W)) u_rel_dly (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .arm(!fault_now),
        .limit(rel_cyc),
        .done(rel_done)
    );

    // Open-drain reset: drive low while a cause stands or delay runs
    assign reset_n_out = 1'b0;
    assign reset_n_oe_n = rel_done;

    // Auto mask set on sequence start, released at selected threshold
    genvar g;
    generate
        for (g = 0; g < SCB_NMON; g++) begin : g_mon
            localparam int B = g + SCB_MON_LSB;
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    mask_r[g] <= 1'b0;
                end else if (ce) begin
                    if (power_up_seq && amon_r[B]) begin
                        mask_r[g] <= rup_r[B] ? !rail_above_uv[g]
                            : !rail_above_off[g];
                    end else if (power_down_seq && amoff_r[B]) begin
                        mask_r[g] <= rdn_r[B] ? rail_above_uv[g]
                            : rail_above_off[g];
                    end else begin
                        mask_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign auto_mask_active = mask_r;
    assign timeout_ms_value = {thi_r, tlo_r};
    assign tout_cyc = 32'(timeout_ms_value) * 32'(MS_CYC);

    scb_delay #(.CW(32)) u_tout (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .arm((power_up_seq || power_down_seq) && |rail_fault_uv),
        .limit(tout_cyc),
        .done(tout_done)
    );

    assign seq_timeout_fault = tout_done;

    // Sticky flags; a new event beats a simultaneous write-one clear
    logic [7:0] ev;
    assign ev = {5'h00, tout_done, esm_done, ov_s2_r || uv_s2_r};
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_r <= 8'h00;
        end else if (ce) begin
            if (reg_wr && reg_addr == SCB_ADDR_INT_STAT) begin
                stat_r <= (stat_r & ~reg_wdata) | ev;
            end else begin
                stat_r <= stat_r | ev;
            end
        end
    end

    a_mr_low: assert property (@(posedge core_clk) disable iff (rst)
        ce && ctrl_r[SCB_BIT_MR] |=> ##1 !reset_n_oe_n)
        else $error("manual reset did not drive low");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        ce && stat_r[1] && !(reg_wr && reg_addr == SCB_ADDR_INT_STAT)
        |=> stat_r[1])
        else $error("flag cleared without write");
    a_bist_pulse: assert property (@(posedge core_clk) disable iff (rst)
        self_test_start |-> $past(reg_wdata[SCB_BIT_BIST]))
        else $error("self test without request");
endmodule

/* scb_host.sv */
// Host model driving register writes and reads on the strobe bus
`timescale 1ns/1ps
module scb_host (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'h1;
        @(negedge core_clk);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge core_clk);
        reg_rd = 1'h0;
        reg_addr = ~a;
        v = reg_rvalid === 1'h1 ? reg_rdata : 8'hxx;
    endtask
endmodule

/* test_supervisor_config_bank.sv */
// Self-checking bench for the supervisor configuration bank
`timescale 1ns/1ps
module test_supervisor_config_bank;
    import scb_pkg::*;
    localparam int MSC = 10;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic ch4_fast_ov = 1'h0;
    logic ch4_fast_uv = 1'h0;
    logic error_signal_monitor = 1'h0;
    logic watchdog_enable_pin = 1'h0;
    logic power_up_seq = 1'h0;
    logic power_down_seq = 1'h0;
    logic [2:0] rail_above_off = 3'h0;
    logic [2:0] rail_above_uv = 3'h0;
    logic [2:0] rail_fault_uv = 3'h0;
    logic reg_wr, reg_rd, reg_rvalid, reset_n_out, reset_n_oe_n;
    logic watchdog_enable, self_test_start, cutoff_invalid;
    logic error_fault, seq_timeout_fault;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] slow_filter_cutoff, auto_mask_active;
    logic [31:0] a, b;
    int miscompares = 0;
    int checked = 0;
    int pulses = 0;
    int n;
    int ms[8] = '{0, 1, 10, 16, 20, 70, 100, 200};
    int deb[4] = '{10, 25, 50, 100};
    logic [7:0] adr[9] = '{SCB_ADDR_CH4_FILT, SCB_ADDR_ESM_DLY,
        SCB_ADDR_GCTRL, SCB_ADDR_AUTO_MASK_POWER_ON, SCB_ADDR_AUTO_MASK_POWER_OFF,
        SCB_ADDR_TOUT_HI, SCB_ADDR_TOUT_LO, SCB_ADDR_REL_UP,
        SCB_ADDR_REL_DN};

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (self_test_start === 1'h1) pulses++;

    scb_bank #(.MS_CYC(MSC)) dut_u (
        .core_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .ch4_fast_ov, .ch4_fast_uv,
        .error_signal_monitor, .watchdog_enable_pin, .rail_above_off,
        .rail_above_uv, .rail_fault_uv, .power_up_seq, .power_down_seq,
        .reset_n_out, .reset_n_oe_n, .watchdog_enable, .self_test_start,
        .slow_filter_cutoff, .cutoff_invalid, .error_fault,
        .auto_mask_active, .seq_timeout_fault
    );
    scb_host host_u (
        .core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        checked++;
        if (v < lo || v > hi) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h..%h", $time, v, lo, hi);
        end
    endtask
    // Returns the lapse in cycles; hitting the limit returns lim, which the route checks expect when not routed
    task automatic wait_for(ref logic s, input logic v, input int lim,
        output int c);
        c = 0;
        while (s !== v && c < lim) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    function automatic logic [2:0] exp_mask(input logic [31:0] x, y);
        logic [7:0] en, sel;
        logic [2:0] past;
        en = x[16] ? x[7:0] : x[15:8];
        sel = x[16] ? y[7:0] : y[15:8];
        past = (sel[3:1] & y[21:19]) | (~sel[3:1] & y[18:16]);
        return en[3:1] & (x[16] ? ~past : past);
    endfunction
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #960us;
        miscompares++;
        give_verdict;
    end

    initial begin
        void'($urandom(32'h79d7e1c4));
        repeat (12) @(negedge core_clk);
        rst = 1'h0;
        chk(8'(reset_n_oe_n), 8'h00);
        foreach (adr[i]) begin
            host_u.rd(adr[i], d);
            chk(d, SCB_REG_RESET);
        end
        wait_for(reset_n_oe_n, 1'h1, 21000, n);
        rng(n, 19960, 20010);
        chk(8'(reset_n_out), 8'h00);
        repeat (2) foreach (adr[i]) begin
            a = $urandom;
            host_u.wr(adr[i], a[7:0]);
            host_u.rd(adr[i], d);
            chk(d, a[7:0]);
        end
        host_u.wr(8'h7b, 8'hff);
        host_u.rd(8'h7b, d);
        chk(d, 8'h00);
        for (int c = 0; c < 8; c++) begin
            host_u.wr(SCB_ADDR_CH4_FILT, 8'(c));
            @(negedge core_clk);
            chk(8'(slow_filter_cutoff), 8'(c));
            chk(8'(cutoff_invalid), 8'(!(c inside {[2:5]})));
        end
        host_u.wr(SCB_ADDR_GCTRL, 8'h01);
        wait_for(reset_n_oe_n, 1'h1, 3000, n);
        // Each route bit is tried against both fault kinds
        for (int k = 0; k < 4; k++) begin
            host_u.wr(SCB_ADDR_CH4_FILT, k[0] ? 8'h12 : 8'h0a);
            ch4_fast_ov = k[1];
            ch4_fast_uv = !k[1];
            wait_for(reset_n_oe_n, 1'h0, 8, n);
            rng(n, k[0] == k[1] ? 0 : 8, k[0] == k[1] ? 6 : 8);
            ch4_fast_ov = 1'h0;
            ch4_fast_uv = 1'h0;
            wait_for(reset_n_oe_n, 1'h1, 40, n);
            rng(n, k[0] == k[1] ? 9 : 0, k[0] == k[1] ? 16 : 0);
        end
        for (int c = 1; c < 8; c++) begin
            host_u.wr(SCB_ADDR_GCTRL, 8'h20 | 8'(c));
            wait_for(reset_n_oe_n, 1'h0, 8, n);
            rng(n, 0, 3);
            host_u.wr(SCB_ADDR_GCTRL, 8'(c));
            wait_for(reset_n_oe_n, 1'h1, 3000, n);
            rng(n, ms[c] * MSC - 2, ms[c] * MSC + 3);
        end
        pulses = 0;
        host_u.wr(SCB_ADDR_GCTRL, 8'h81);
        host_u.wr(SCB_ADDR_GCTRL, 8'h81);
        host_u.wr(SCB_ADDR_GCTRL, 8'h01);
        repeat (4) @(negedge core_clk);
        rng(pulses, 2, 2);
        for (int k = 0; k < 4; k++) begin
            watchdog_enable_pin = k[0];
            host_u.wr(SCB_ADDR_GCTRL, {1'h0, k[1], 6'h01});
            repeat (4) @(negedge core_clk);
            chk(8'(watchdog_enable), 8'(k[0] & k[1]));
        end
        host_u.wr(SCB_ADDR_ESM_DLY, 8'h00);
        for (int c = 0; c < 4; c++) begin
            host_u.wr(SCB_ADDR_GCTRL, {3'h0, 2'(c), 3'h1});
            error_signal_monitor = 1'h1;
            wait_for(error_fault, 1'h1, 20000, n);
            rng(n, deb[c] * 100 + MSC - 2, deb[c] * 100 + MSC + 8);
            error_signal_monitor = 1'h0;
            wait_for(error_fault, 1'h0, 20000, n);
        end
        host_u.wr(SCB_ADDR_ESM_DLY, 8'hff);
        host_u.wr(SCB_ADDR_GCTRL, 8'h01);
        error_signal_monitor = 1'h1;
        wait_for(error_fault, 1'h1, 20000, n);
        rng(n, 1000 + 864 * MSC - 2, 1000 + 864 * MSC + 8);
        error_signal_monitor = 1'h0;
        wait_for(error_fault, 1'h0, 3000, n);
        host_u.rd(SCB_ADDR_INT_STAT, d);
        chk(d & 8'h02, 8'h02);
        host_u.wr(SCB_ADDR_INT_STAT, 8'h02);
        host_u.rd(SCB_ADDR_INT_STAT, d);
        chk(d & 8'h02, 8'h00);
        // Sequence flags drop while the mask setup changes
        for (int k = 0; k < 16; k++) begin
            a = $urandom;
            b = $urandom;
            power_up_seq = 1'h0;
            power_down_seq = 1'h0;
            host_u.wr(SCB_ADDR_AUTO_MASK_POWER_ON, a[7:0]);
            host_u.wr(SCB_ADDR_AUTO_MASK_POWER_OFF, a[15:8]);
            host_u.wr(SCB_ADDR_REL_UP, b[7:0]);
            host_u.wr(SCB_ADDR_REL_DN, b[15:8]);
            rail_above_off = b[18:16];
            rail_above_uv = b[21:19];
            power_up_seq = a[16];
            power_down_seq = !a[16];
            repeat (3) @(negedge core_clk);
            chk(8'(auto_mask_active), 8'(exp_mask(a, b)));
        end
        power_up_seq = 1'h0;
        power_down_seq = 1'h0;
        host_u.wr(SCB_ADDR_TOUT_HI, 8'h01);
        host_u.wr(SCB_ADDR_TOUT_LO, 8'h02);
        power_up_seq = 1'h1;
        rail_fault_uv = 3'h4;
        wait_for(seq_timeout_fault, 1'h1, 4000, n);
        rng(n, 258 * MSC - 3, 258 * MSC + 6);
        give_verdict;
    end
endmodule
